// ==== reset_state_initializer.sv ====
// Reset-state initializer: gathers reset sources, drives register
// reset lines and init values, floats ports, fetches the vector.
// Assumes internal sources are on i_sys_clk; the pin is asynchronous.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps

module reset_state_initializer #(
    parameter int PORT_W   = 8,
    parameter int LOW_BIT  = 0
) (
    // Clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rstn,
    // Reset sources
    input  wire logic                      i_ext_rst_n,
    input  wire rst_init_pkg::src_req_t    i_src_req,
    input  wire logic                      i_standby,
    // Port pins from port logic
    input  wire logic [PORT_W-1:0]         i_port_oe,
    input  wire logic [PORT_W-1:0]         i_port_out,
    // Vector memory
    input  wire logic [7:0]                i_vec_data,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    // Reset outputs
    output rst_init_pkg::rst_lines_t       o_rst_lines,
    output rst_init_pkg::init_values_t     o_init,
    output logic                           o_rst_active,
    output logic                           o_ram_retain,
    // Port pin drive
    output logic [PORT_W-1:0]              o_port_oe,
    output logic [PORT_W-1:0]              o_port_out,
    // Vector fetch and core start
    output logic                           o_vec_rd,
    output logic [15:0]                    o_vec_addr,
    output logic [15:0]                    o_instruction_pointer,
    output logic                           o_cpu_run
);
    generate
        if (LOW_BIT >= PORT_W || LOW_BIT < 0) begin : g_bad_low_bit
            $error("LOW_BIT outside the port");
        end
    endgenerate

    localparam logic [PORT_W-1:0] LOW_MASK =
        PORT_W'(1) << LOW_BIT;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_FETCH_LO,
        ST_FETCH_HI,
        ST_LOAD,
        ST_RUN
    } state_t;

    state_t                     state;
    state_t                     next_state;
    logic                       ext_meta;
    logic                       ext_sync_n;
    logic                       soft_req;
    logic                       reset_req;
    logic [7:0]                 vec_lo;
    logic [rst_init_pkg::SRC_W-1:0] src_seen;
    logic [rst_init_pkg::SRC_W-1:0] src_now;
    logic                       apb_done;
    logic                       apb_wr;

    // Pin passes two flops before use
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_meta   <= 1'b0;
            ext_sync_n <= 1'b0;
        end else begin
            ext_meta   <= i_ext_rst_n;
            ext_sync_n <= ext_meta;
        end
    end

    // Every source funnels into one request
    assign src_now = {~ext_sync_n, i_src_req.wdt, i_src_req.clm,
                      i_src_req.poc, i_src_req.lvi, soft_req};
    assign reset_req = |src_now;

    always_comb begin
        next_state = state;
        case (state)
            ST_HOLD:     next_state = ST_FETCH_LO;
            ST_FETCH_LO: next_state = ST_FETCH_HI;
            ST_FETCH_HI: next_state = ST_LOAD;
            ST_LOAD:     next_state = ST_RUN;
            ST_RUN:      next_state = ST_RUN;
            default:     next_state = ST_HOLD;
        endcase
        if (reset_req) begin
            next_state = ST_HOLD;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Lines rise and fall together; watchdog line included
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rst_lines <= '1;
        end else begin
            o_rst_lines <= {$bits(rst_init_pkg::rst_lines_t)
                           {next_state == ST_HOLD}};
        end
    end

    // Same constant bundle for every source
    // Port two latch and stack pointer get no value here on purpose.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_init <= rst_init_pkg::INIT_VALUES;
        end else if (next_state == ST_HOLD) begin
            o_init <= rst_init_pkg::INIT_VALUES;
        end else begin
            o_init <= '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rst_active <= 1'b1;
            o_cpu_run    <= 1'b0;
        end else begin
            o_rst_active <= next_state != ST_RUN;
            o_cpu_run    <= next_state == ST_RUN;
        end
    end

    // Standby state is caught as the reset is entered from run; the i_rstn
    // reset never retains, but a poc request retains like any other source
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ram_retain <= 1'b0;
        end else if (state == ST_RUN && next_state == ST_HOLD) begin
            o_ram_retain <= i_standby;
        end
    end

    // Ports float until the core runs, one bit held low
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_port_oe  <= LOW_MASK;
            o_port_out <= '0;
        end else if (next_state != ST_RUN) begin
            o_port_oe  <= LOW_MASK;
            o_port_out <= '0;
        end else begin
            o_port_oe  <= i_port_oe;
            o_port_out <= i_port_out;
        end
    end

    // Vector read: memory answers one cycle after the address
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_vec_rd   <= 1'b0;
            o_vec_addr <= rst_init_pkg::VEC_LO_ADDR;
        end else begin
            o_vec_rd   <= next_state == ST_FETCH_LO ||
                          next_state == ST_FETCH_HI;
            o_vec_addr <= (next_state == ST_FETCH_HI) ?
                          rst_init_pkg::VEC_HI_ADDR :
                          rst_init_pkg::VEC_LO_ADDR;
        end
    end

    // Pointer value is meaningless until loaded
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            vec_lo                <= 8'h00;
            o_instruction_pointer <= 16'h0000;
        end else begin
            if (state == ST_FETCH_HI && next_state == ST_LOAD) begin
                vec_lo <= i_vec_data;
            end
            if (state == ST_LOAD && next_state == ST_RUN) begin
                o_instruction_pointer <= {i_vec_data, vec_lo};
            end
        end
    end

    // APB: one wait state, answer registered
    assign apb_done = psel && penable && pready;
    assign apb_wr   = apb_done && pwrite && !pslverr;

    function automatic logic addr_mapped(input logic [7:0] a);
        return a == rst_init_pkg::ADDR_CTRL ||
               a == rst_init_pkg::ADDR_STATUS ||
               a == rst_init_pkg::ADDR_IPTR;
    endfunction

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    rst_init_pkg::ADDR_STATUS: begin
                        prdata[rst_init_pkg::STAT_ACTIVE_BIT] <=
                            o_rst_active;
                        prdata[rst_init_pkg::STAT_RETAIN_BIT] <=
                            o_ram_retain;
                        prdata[rst_init_pkg::STAT_SRC_LSB +:
                               rst_init_pkg::SRC_W] <= src_seen;
                    end
                    rst_init_pkg::ADDR_IPTR: begin
                        prdata[15:0] <= o_instruction_pointer;
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Software reset: one-cycle request from a control write
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            soft_req <= 1'b0;
        end else begin
            soft_req <= apb_wr && paddr == rst_init_pkg::ADDR_CTRL &&
                        pwdata[rst_init_pkg::CTRL_SOFT_BIT];
        end
    end

    // Sticky source record, write one to clear, a new event wins
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            src_seen <= '0;
        end else begin
            if (apb_wr && paddr == rst_init_pkg::ADDR_STATUS) begin
                src_seen <= (src_seen & ~pwdata[rst_init_pkg::STAT_SRC_LSB
                            +: rst_init_pkg::SRC_W]) | src_now;
            end else begin
                src_seen <= src_seen | src_now;
            end
        end
    end

    sequence s_vec_lo;
        o_vec_rd && o_vec_addr == rst_init_pkg::VEC_LO_ADDR;
    endsequence

    sequence s_vec_hi;
        o_vec_rd && o_vec_addr == rst_init_pkg::VEC_HI_ADDR;
    endsequence

    chk_port_float: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        reset_req |=> (o_port_oe == LOW_MASK && o_port_out == '0))
        else $error("ports not floated during reset");

    chk_wdt_self: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        i_src_req.wdt |=> o_rst_lines.wdt && o_rst_lines.core)
        else $error("watchdog reset missed its own line");

    chk_init_bundle: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        reset_req |=> o_init == rst_init_pkg::INIT_VALUES)
        else $error("init values wrong during reset");

    chk_ram_keep: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        $rose(o_rst_active) |-> o_ram_retain == $past(i_standby))
        else $error("standby retention not captured");

    chk_lines_together: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (&o_rst_lines) == (|o_rst_lines))
        else $error("reset lines not asserted together");

    chk_lines_persist: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        reset_req ##1 reset_req |-> o_rst_lines.core && o_rst_active)
        else $error("reset lines dropped while requested");

    chk_vector_walk: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        ($fell(o_rst_lines.core) && !reset_req) |->
        s_vec_lo ##1 (s_vec_hi or reset_req))
        else $error("vector fetch order wrong");

    chk_ip_load: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        $rose(o_cpu_run) |-> o_instruction_pointer ==
        {$past(i_vec_data, 1), $past(i_vec_data, 2)})
        else $error("instruction pointer not taken from vector");

    chk_run_ports: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        o_cpu_run |-> (o_port_oe == $past(i_port_oe) &&
                       o_port_out == $past(i_port_out)))
        else $error("ports not handed to port logic in run");

    chk_apb_ready: assert property (
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (psel && penable && !pready) |=> pready)
        else $error("APB answer late");
endmodule

// ==== rst_init_pkg.sv ====
// Constants and carrier types for the reset-state initializer.
// Assumes peripherals load their registers from the init bundle
// while their reset line is high.
package rst_init_pkg;
    // APB register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IPTR   = 8'h08;

    // Field positions
    localparam int CTRL_SOFT_BIT   = 0;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_RETAIN_BIT = 1;
    localparam int STAT_SRC_LSB    = 2;
    localparam int SRC_W           = 6;

    // Reset vector locations
    localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
    localparam logic [15:0] VEC_HI_ADDR = 16'h0001;

    // Initial register values
    localparam logic [7:0]  PSW_INIT      = 8'h02;
    localparam logic [7:0]  LATCH_INIT    = 8'h00;
    localparam logic [7:0]  DIR_INIT      = 8'hff;
    localparam logic [7:0]  PULLUP_INIT   = 8'h00;
    localparam logic [7:0]  ISC_INIT      = 8'h00;
    localparam logic [7:0]  MEMSIZE_INIT  = 8'hcf;
    localparam logic [7:0]  EXPRAM_INIT   = 8'h0c;
    localparam logic [7:0]  CLKCTL_INIT   = 8'h00;
    localparam logic [15:0] WIDE16_INIT   = 16'h0000;
    localparam logic [7:0]  WIDECTL_INIT  = 8'h00;
    localparam logic [7:0]  BYTETMR_INIT  = 8'h00;
    localparam logic [7:0]  INTVTMR_INIT  = 8'h00;
    localparam logic [7:0]  WATCH_INIT    = 8'h00;
    localparam logic [7:0]  CLKOUT_INIT   = 8'h00;

    // Internal reset sources
    typedef struct packed {
        logic wdt;
        logic clm;
        logic poc;
        logic lvi;
    } src_req_t;

    // Per-group register reset lines
    typedef struct packed {
        logic core;
        logic port;
        logic memcfg;
        logic clkctl;
        logic wide_tmr;
        logic byte_tmr;
        logic intv_tmr;
        logic watch;
        logic clkout;
        logic wdt;
    } rst_lines_t;

    // Values presented to peripherals during reset
    typedef struct packed {
        logic [7:0]  program_status_word;
        logic [7:0]  port_latch;
        logic [7:0]  port_direction_reg;
        logic [7:0]  pullup_option_reg;
        logic [7:0]  input_switch_ctrl;
        logic [7:0]  memory_size_switch;
        logic [7:0]  expansion_ram_size_switch;
        logic [7:0]  clock_ctrl_regs;
        logic [15:0] wide_timer_count;
        logic [15:0] wide_timer_capture_compare;
        logic [7:0]  wide_timer_ctrl_regs;
        logic [7:0]  byte_timer_regs;
        logic [7:0]  interval_timer_regs;
        logic [7:0]  watch_timer_mode;
        logic [7:0]  clock_out_select;
    } init_values_t;

    localparam init_values_t INIT_VALUES = '{
        program_status_word:        PSW_INIT,
        port_latch:                 LATCH_INIT,
        port_direction_reg:         DIR_INIT,
        pullup_option_reg:          PULLUP_INIT,
        input_switch_ctrl:          ISC_INIT,
        memory_size_switch:         MEMSIZE_INIT,
        expansion_ram_size_switch:  EXPRAM_INIT,
        clock_ctrl_regs:            CLKCTL_INIT,
        wide_timer_count:           WIDE16_INIT,
        wide_timer_capture_compare: WIDE16_INIT,
        wide_timer_ctrl_regs:       WIDECTL_INIT,
        byte_timer_regs:            BYTETMR_INIT,
        interval_timer_regs:        INTVTMR_INIT,
        watch_timer_mode:           WATCH_INIT,
        clock_out_select:           CLKOUT_INIT
    };
endpackage

// ==== reset_peer_model.sv ====
// Far-side model: vector memory read by the initializer and a
// peripheral bank that loads the init bundle while its line is high.
// Assumes one clock; vector data follows the address by one cycle.
`timescale 1ns/1ps

module reset_peer_model (
    // Clock
    input  wire logic                       i_sys_clk,
    // Vector memory
    input  wire logic                       i_vec_rd,
    input  wire logic [15:0]                i_vec_addr,
    input  wire logic [15:0]                i_vector,
    output logic [7:0]                      o_vec_data,
    // Peripheral register loading
    input  wire rst_init_pkg::rst_lines_t   i_rst_lines,
    input  wire rst_init_pkg::init_values_t i_init,
    output rst_init_pkg::init_values_t      o_regs
);
    logic [7:0] vec_q = 8'h5a;

    assign o_vec_data = vec_q;

    // Outside a fetch the bus is not held, so it toggles every cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_vec_rd && i_vec_addr == rst_init_pkg::VEC_LO_ADDR) begin
            vec_q <= i_vector[7:0];
        end else if (i_vec_rd && i_vec_addr == rst_init_pkg::VEC_HI_ADDR) begin
            vec_q <= i_vector[15:8];
        end else begin
            vec_q <= ~vec_q;
        end
    end

    // Registers keep what they loaded once the line drops
    always_ff @(posedge i_sys_clk) begin
        if (i_rst_lines.core) begin
            o_regs <= i_init;
        end
    end
endmodule

// ==== tb.sv ====
// Self-checking bench for the reset-state initializer over APB.
// Assumes the peer model supplies vector bytes and peripheral regs.
`timescale 1ns/1ps

module tb;
    logic                       i_sys_clk   = 1'b0;
    logic                       i_rstn      = 1'b0;
    logic                       i_ext_rst_n = 1'b1;
    rst_init_pkg::src_req_t     i_src_req   = '0;
    logic                       i_standby   = 1'b0;
    logic [7:0]                 i_port_oe   = 8'ha5;
    logic [7:0]                 i_port_out  = 8'h3c;
    logic                       psel        = 1'b0;
    logic                       penable     = 1'b0;
    logic                       pwrite      = 1'b0;
    logic [7:0]                 paddr       = 8'h00;
    logic [31:0]                pwdata      = 32'h0;
    logic [15:0]                vector      = 16'h1234;
    logic [7:0]                 i_vec_data;
    logic                       pready, pslverr, err;
    logic [31:0]                prdata, rd;
    rst_init_pkg::rst_lines_t   o_rst_lines;
    rst_init_pkg::init_values_t o_init, periph_regs;
    logic                       o_rst_active, o_ram_retain;
    logic                       o_vec_rd, o_cpu_run;
    logic [7:0]                 o_port_oe, o_port_out;
    logic [15:0]                o_vec_addr, o_instruction_pointer;
    int                         fails = 0;
    int                         n_compared = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    reset_state_initializer #(.PORT_W(8), .LOW_BIT(0)) u_dut (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ext_rst_n(i_ext_rst_n),
        .i_src_req(i_src_req), .i_standby(i_standby),
        .i_port_oe(i_port_oe), .i_port_out(i_port_out),
        .i_vec_data(i_vec_data), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .o_rst_lines(o_rst_lines),
        .o_init(o_init), .o_rst_active(o_rst_active),
        .o_ram_retain(o_ram_retain), .o_port_oe(o_port_oe),
        .o_port_out(o_port_out), .o_vec_rd(o_vec_rd),
        .o_vec_addr(o_vec_addr),
        .o_instruction_pointer(o_instruction_pointer),
        .o_cpu_run(o_cpu_run));

    reset_peer_model u_peer (
        .i_sys_clk(i_sys_clk), .i_vec_rd(o_vec_rd), .i_vec_addr(o_vec_addr),
        .i_vector(vector), .o_vec_data(i_vec_data),
        .i_rst_lines(o_rst_lines), .i_init(o_init), .o_regs(periph_regs));

    task summarize;
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("[ERR] %0t bus answer missing", $time);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task chk_vals(input rst_init_pkg::init_values_t v);
        chk(v[135:104], 32'h02_00_ff_00);
        chk(v[103:72], 32'h00_cf_0c_00);
        chk(v[71:40], 32'h0);
        chk(v[39:8], 32'h0);
        chk({24'h0, v[7:0]}, 32'h0);
    endtask

    task snap(input logic ret);
        chk({22'h0, o_rst_lines}, 32'h3ff);
        chk_vals(o_init);
        chk({16'h0, o_port_oe, o_port_out}, 32'h0100);
        chk({29'h0, o_rst_active, o_cpu_run, o_ram_retain},
            {29'h0, 1'b1, 1'b0, ret});
    endtask

    task wait_run;
        int n;
        n = 0;
        while (o_cpu_run !== 1'b1 && n < 40) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        chk({16'h0, o_instruction_pointer}, {16'h0, vector});
    endtask

    // Source k: 0 pin, 1..4 wdt/clm/poc/lvi, 5 software write
    task run_src(input int k, input int hold, input logic sb);
        int cnt;
        int i;
        apb(1'b1, rst_init_pkg::ADDR_STATUS, 32'h0000_00fc);
        @(posedge i_sys_clk);
        i_standby <= sb;
        vector    <= 16'h1234 + 16'(k) * 16'h1111;
        if (k == 5) begin
            apb(1'b1, rst_init_pkg::ADDR_CTRL, 32'h1);
        end else if (k == 0) begin
            i_ext_rst_n <= 1'b0;
        end else begin
            i_src_req <= 4'(1 << (4 - k));
        end
        cnt = 0;
        for (i = 0; i < hold + 8; i++) begin
            @(posedge i_sys_clk);
            if (i == hold - 1) begin
                i_ext_rst_n <= 1'b1;
                i_src_req   <= '0;
            end
            #1;
            if (o_rst_lines === 10'h3ff) begin
                cnt++;
                if (cnt == 1) snap(sb);
            end
        end
        chk(32'(cnt), (k == 5) ? 32'd1 : 32'(hold));
        wait_run();
        chk({16'h0, o_port_oe, o_port_out}, 32'h0000_a53c);
        chk_vals(periph_regs);
        apb(1'b0, rst_init_pkg::ADDR_STATUS, 32'h0);
        chk(rd, (32'h1 << (7 - k)) | {30'h0, sb, 1'b0});
        apb(1'b0, rst_init_pkg::ADDR_IPTR, 32'h0);
        chk(rd, {16'h0, vector});
        @(posedge i_sys_clk);
        i_standby <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fails++;
        summarize();
    end

    initial begin
        repeat (16) @(posedge i_sys_clk);
        #1;
        snap(1'b0);
        @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        wait_run();
        for (int k = 0; k < 6; k++) begin
            run_src(k, 3 + k, k == 4);
        end
        // Unmapped place and read-only pointer
        apb(1'b0, 8'h0c, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, rst_init_pkg::ADDR_IPTR, 32'h0000_ffff);
        apb(1'b0, rst_init_pkg::ADDR_IPTR, 32'h0);
        chk(rd, {16'h0, vector});
        apb(1'b0, rst_init_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule
